// *** tb/host_model.sv ***
// Host model driving the register ports at the falling clock edge.
`timescale 1ns/1ps
module host_model (
	input wire logic core_clk,
	output logic wr_en,
	output logic [7:0] wr_addr,
	output logic [7:0] wr_data,
	output logic [7:0] rd_addr,
	input wire logic [7:0] rd_data,
	input wire logic rd_hit
);
	initial begin
		wr_en = 1'b0;
		wr_addr = 8'h00;
		wr_data = 8'h00;
		rd_addr = 8'h00;
	end
	// One strobe; idle lines then show the inverse so stale values are never trusted.
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge core_clk);
		wr_en = 1'b1;
		wr_addr = a;
		wr_data = d;
		@(negedge core_clk);
		wr_en = 1'b0;
		wr_addr = ~a;
		wr_data = ~d;
	endtask
	// Read data stands one edge after the address.
	task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic h);
		@(negedge core_clk);
		rd_addr = a;
		@(negedge core_clk);
		d = rd_data;
		h = rd_hit;
	endtask
endmodule

// *** tb/setpoint_asserts.sv ***
// Checker of the set-point bank's port timing and decode relations.
`timescale 1ns/1ps
module setpoint_asserts (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic wr_en,
	input wire logic [7:0] wr_addr,
	input wire logic [7:0] wr_data,
	input wire logic [2:0] roof_floor_sel,
	input wire logic [2:0] conv3_current_limit,
	input wire logic [12:0] conv3_limit_ma,
	input wire logic [2:0] conv3_ramp_speed,
	input wire logic [11:0] conv3_ramp_rate,
	input wire logic [11:0] conv0_target_mv,
	input wire logic [11:0] conv1_target_mv,
	input wire logic [11:0] conv2_target_mv
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rstn);
	// The limit in mA must track the stored limit code whenever that code is two or more.
	property p_limit_ma;
		conv3_current_limit >= 3'h2 |-> conv3_limit_ma == 13'h9C4 + 13'h1F4 * (conv3_current_limit - 3'h2);
	endproperty
	a_limit_ma: assert property (p_limit_ma) else $error("limit decode wrong");
	// A limit write shows two edges later, whatever the converter is doing.
	property p_limit_write;
		wr_en && wr_addr == 8'h09 |=> ##1 conv3_current_limit == $past(wr_data[5:3], 2);
	endproperty
	a_limit_write: assert property (p_limit_write) else $error("limit write lost");
	// Without a write the limit must not drift.
	property p_limit_hold;
		(!(wr_en && wr_addr == 8'h09)) [*2] |=> $stable(conv3_current_limit);
	endproperty
	a_limit_hold: assert property (p_limit_hold) else $error("limit changed unasked");
	property p_slew;
		conv3_ramp_speed == 3'h7 |-> conv3_ramp_rate == 12'h028;
	endproperty
	a_slew: assert property (p_slew) else $error("slowest slew wrong");
	// Defaults reach the targets right after reset release.
	property p_reset;
		$rose(rstn) ##0 roof_floor_sel == 3'h0 |=> conv0_target_mv == 12'h384 &&
			conv1_target_mv == 12'h4B0 && conv2_target_mv == 12'h708;
	endproperty
	a_reset: assert property (p_reset) else $error("default targets wrong");
	property p_seg0;
		wr_en && wr_addr == 8'h0A && wr_data == 8'h00 && !roof_floor_sel[0] |=> ##1 conv0_target_mv == 12'h1F4;
	endproperty
	a_seg0: assert property (p_seg0) else $error("lowest code wrong");
	property p_seg1;
		wr_en && wr_addr == 8'h0A && wr_data == 8'h9D && !roof_floor_sel[0] |=> ##1 conv0_target_mv == 12'h578;
	endproperty
	a_seg1: assert property (p_seg1) else $error("mid segment top wrong");
	property p_seg2;
		wr_en && wr_addr == 8'h0A && wr_data == 8'hFF && !roof_floor_sel[0] |=> ##1 conv0_target_mv == 12'hD20;
	endproperty
	a_seg2: assert property (p_seg2) else $error("top code wrong");
	c_limit_top: cover property (conv3_current_limit == 3'h7);
	c_slew_slow: cover property (conv3_ramp_speed == 3'h7);
	c_floor_mode: cover property (roof_floor_sel == 3'h7);
endmodule

// *** tb/testbench.sv ***
// Self-checking bench for the converter set-point register bank.
`timescale 1ns/1ps
module testbench;
	logic core_clk;
	logic rstn;
	logic [2:0] roof_floor_sel;
	logic [2:0] enable_pin;
	logic wr_en;
	logic [7:0] wr_addr, wr_data, rd_addr, rd_data;
	logic rd_hit;
	logic [2:0] conv3_current_limit, conv3_ramp_speed;
	logic [12:0] conv3_limit_ma;
	logic [11:0] conv3_ramp_rate, conv0_target_mv, conv1_target_mv, conv2_target_mv;
	int error_cnt = 0;
	int num_checks = 0;
	converter_setpoint_registers DUT (
		.core_clk(core_clk),
		.rstn(rstn),
		.wr_en(wr_en),
		.wr_addr(wr_addr),
		.wr_data(wr_data),
		.rd_addr(rd_addr),
		.roof_floor_sel(roof_floor_sel),
		.enable_pin(enable_pin),
		.rd_data(rd_data),
		.rd_hit(rd_hit),
		.conv3_current_limit(conv3_current_limit),
		.conv3_limit_ma(conv3_limit_ma),
		.conv3_ramp_speed(conv3_ramp_speed),
		.conv3_ramp_rate(conv3_ramp_rate),
		.conv0_target_mv(conv0_target_mv),
		.conv1_target_mv(conv1_target_mv),
		.conv2_target_mv(conv2_target_mv)
	);
	host_model host (
		.core_clk(core_clk),
		.wr_en(wr_en),
		.wr_addr(wr_addr),
		.wr_data(wr_data),
		.rd_addr(rd_addr),
		.rd_data(rd_data),
		.rd_hit(rd_hit)
	);
	task automatic cmp(input string n, input logic [12:0] e, input logic [12:0] g);
		num_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask
	// Expected millivolts of a set-point code.
	function automatic logic [12:0] mv(input logic [7:0] c);
		if (c < 8'h18) return 13'h1F4 + 13'(c) * 13'h00A;
		if (c < 8'h9E) return 13'h2DF + 13'(c - 8'h18) * 13'h005;
		return 13'h58C + 13'(c - 8'h9E) * 13'h014;
	endfunction
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	// Defaults; a write to an unmapped address must leave no trace.
	task automatic t_regs();
		logic [7:0] d;
		logic h;
		logic [7:0] dflt [7] = '{8'h2A, 8'h39, 8'h00, 8'h75, 8'h00, 8'hB1, 8'h00};
		cmp("conv0_mv", 13'h384, 13'(conv0_target_mv));
		cmp("conv1_mv", 13'h4B0, 13'(conv1_target_mv));
		cmp("conv2_mv", 13'h708, 13'(conv2_target_mv));
		host.wr(8'h10, 8'h55);
		for (int i = 0; i < 7; i++) begin
			host.rd(8'h09 + 8'(i), d, h);
			cmp("reg", 13'(dflt[i]), 13'(d));
			cmp("hit", 13'h0001, 13'(h));
		end
		host.rd(8'h10, d, h);
		cmp("unmapped", 13'h0000, {4'h0, h, d});
		$display("t_regs done");
	endtask
	// Limit codes two to seven and every slew code rewritten while running, then a saturating low limit code.
	task automatic t_conv3();
		logic [12:0] rate [8] = '{13'hBB8, 13'h5DC, 13'h3E8, 13'h2EE, 13'h17C, 13'h0BE,
			13'h05E, 13'h028};
		logic [7:0] d;
		logic h;
		for (int i = 0; i < 8; i++) begin
			host.wr(8'h09, {2'b00, 3'(2 + i % 6), 3'(i)});
			@(negedge core_clk);
			cmp("limit_ma", 13'h9C4 + 13'h1F4 * 13'(i % 6), conv3_limit_ma);
			cmp("ramp_rate", rate[i], 13'(conv3_ramp_rate));
			cmp("limit_code", 13'(2 + i % 6), 13'(conv3_current_limit));
			cmp("ramp_code", 13'(i), 13'(conv3_ramp_speed));
		end
		host.wr(8'h09, 8'hC1);
		@(negedge core_clk);
		cmp("limit_ma_low", 13'h09C4, conv3_limit_ma);
		cmp("ramp_rate_1", rate[1], 13'(conv3_ramp_rate));
		host.rd(8'h09, d, h);
		cmp("reg_09", 13'h00C1, 13'(d));
		$display("t_conv3 done");
	endtask
	// Segment ends of the set-point code.
	task automatic t_codes();
		logic [7:0] c [7] = '{8'h00, 8'h17, 8'h18, 8'h9D, 8'h9E, 8'hFF, 8'h39};
		foreach (c[i]) begin
			host.wr(8'h0A, c[i]);
			@(negedge core_clk);
			cmp("conv0_mv", mv(c[i]), 13'(conv0_target_mv));
		end
		$display("t_codes done");
	endtask
	// Floor codes with pins low, normal codes with pins high; pins take three edges.
	task automatic t_floor();
		host.wr(8'h0B, 8'h18);
		host.wr(8'h0D, 8'h9E);
		host.wr(8'h0F, 8'h17);
		roof_floor_sel = 3'h7;
		repeat (4) @(negedge core_clk);
		cmp("floor0", 13'h2DF, 13'(conv0_target_mv));
		cmp("floor1", 13'h58C, 13'(conv1_target_mv));
		cmp("floor2", 13'h2DA, 13'(conv2_target_mv));
		enable_pin = 3'h7;
		repeat (4) @(negedge core_clk);
		cmp("roof0", 13'h384, 13'(conv0_target_mv));
		cmp("roof1", 13'h4B0, 13'(conv1_target_mv));
		cmp("roof2", 13'h708, 13'(conv2_target_mv));
		$display("t_floor done");
	endtask
	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end
	// Bounds the whole run.
	initial begin
		#100000;
		error_cnt++;
		wrap_up();
	end
	initial begin
		rstn = 1'b0;
		roof_floor_sel = 3'h0;
		enable_pin = 3'h0;
		repeat (8) @(negedge core_clk);
		rstn = 1'b1;
		repeat (2) @(negedge core_clk);
		t_regs();
		t_conv3();
		t_codes();
		t_floor();
		wrap_up();
	end
endmodule
bind converter_setpoint_registers setpoint_asserts chk (
	.core_clk(core_clk),
	.rstn(rstn),
	.wr_en(wr_en),
	.wr_addr(wr_addr),
	.wr_data(wr_data),
	.roof_floor_sel(roof_floor_sel),
	.conv3_current_limit(conv3_current_limit),
	.conv3_limit_ma(conv3_limit_ma),
	.conv3_ramp_speed(conv3_ramp_speed),
	.conv3_ramp_rate(conv3_ramp_rate),
	.conv0_target_mv(conv0_target_mv),
	.conv1_target_mv(conv1_target_mv),
	.conv2_target_mv(conv2_target_mv)
);

// *** verilog/converter_setpoint_registers.sv ***
// Register bank holding converter three limit/slew and converters zero..two set points.
`timescale 1ns/1ps
module converter_setpoint_registers (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic wr_en,
	input wire logic [7:0] wr_addr,
	input wire logic [7:0] wr_data,
	input wire logic [7:0] rd_addr,
	input wire logic [2:0] roof_floor_sel,
	input wire logic [2:0] enable_pin,
	output logic [7:0] rd_data,
	output logic rd_hit,
	output logic [2:0] conv3_current_limit,
	output logic [12:0] conv3_limit_ma,
	output logic [2:0] conv3_ramp_speed,
	output logic [11:0] conv3_ramp_rate,
	output logic [11:0] conv0_target_mv,
	output logic [11:0] conv1_target_mv,
	output logic [11:0] conv2_target_mv
);
	// The bank keeps the seven writable codes and decodes them into physical units.
	// Every result leaves through an output flop, so a consumer sees each register
	// change one edge after the register itself takes it.
	// Limitation: no range check is made on a set point; every 8-bit value is legal.
	// Stored registers.
	logic [7:0] limit_slew;
	logic [7:0] conv0_voltage_code;
	logic [7:0] conv0_low_voltage_code;
	logic [7:0] conv1_voltage_code;
	logic [7:0] conv1_low_voltage_code;
	logic [7:0] conv2_voltage_code;
	logic [7:0] conv2_low_voltage_code;
	// Next values computed by the write decode.
	logic [7:0] next_limit_slew;
	logic [7:0] next_conv0_voltage_code;
	logic [7:0] next_conv0_low_voltage_code;
	logic [7:0] next_conv1_voltage_code;
	logic [7:0] next_conv1_low_voltage_code;
	logic [7:0] next_conv2_voltage_code;
	logic [7:0] next_conv2_low_voltage_code;
	// Pin synchroniser stages; only the second stage is read by logic.
	logic [2:0] pin_meta;
	logic [2:0] pin_sync;
	// Selected code per converter and its decoded voltage.
	logic [7:0] active_code [3];
	logic [11:0] decoded_mv [3];
	// Read path and outputs, registered.
	logic [7:0] next_rd_data;
	logic next_rd_hit;
	logic [12:0] next_limit_ma;
	logic [11:0] next_ramp_rate;
	// Fields split out of the limit and slew register.
	logic [2:0] limit_field;
	logic [2:0] slew_field;

	// Write decode: a write to any of the seven addresses takes effect on the next edge, converter running or not.
	always_comb begin
		// Hold every register unless a write names it.
		next_limit_slew = limit_slew;
		next_conv0_voltage_code = conv0_voltage_code;
		next_conv0_low_voltage_code = conv0_low_voltage_code;
		next_conv1_voltage_code = conv1_voltage_code;
		next_conv1_low_voltage_code = conv1_low_voltage_code;
		next_conv2_voltage_code = conv2_voltage_code;
		next_conv2_low_voltage_code = conv2_low_voltage_code;
		if (wr_en) begin
			if (wr_addr == setpoint_pkg::ADDR_CONV3_LIMIT_SLEW) begin
				// Converter three limit and slew; reserved bits are kept as written.
				next_limit_slew = wr_data;
			end else if (wr_addr == setpoint_pkg::ADDR_CONV0_SETPOINT) begin
				// Converter zero normal set point.
				next_conv0_voltage_code = wr_data;
			end else if (wr_addr == setpoint_pkg::ADDR_CONV0_LOW) begin
				// Converter zero floor set point.
				next_conv0_low_voltage_code = wr_data;
			end else if (wr_addr == setpoint_pkg::ADDR_CONV1_SETPOINT) begin
				// Converter one normal set point.
				next_conv1_voltage_code = wr_data;
			end else if (wr_addr == setpoint_pkg::ADDR_CONV1_LOW) begin
				// Converter one floor set point.
				next_conv1_low_voltage_code = wr_data;
			end else if (wr_addr == setpoint_pkg::ADDR_CONV2_SETPOINT) begin
				// Converter two normal set point.
				next_conv2_voltage_code = wr_data;
			end else if (wr_addr == setpoint_pkg::ADDR_CONV2_LOW) begin
				// Converter two floor set point.
				next_conv2_low_voltage_code = wr_data;
			end
			// Writes to other addresses belong to other banks and are ignored here.
		end
	end

	// Register stage with synchronous reset to the documented defaults.
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			// Defaults; the reserved bits of the limit register come up as zero.
			limit_slew <= setpoint_pkg::RST_CONV3_LIMIT_SLEW;
			conv0_voltage_code <= setpoint_pkg::RST_CONV0_SETPOINT;
			conv0_low_voltage_code <= setpoint_pkg::RST_LOW_SETPOINT;
			conv1_voltage_code <= setpoint_pkg::RST_CONV1_SETPOINT;
			conv1_low_voltage_code <= setpoint_pkg::RST_LOW_SETPOINT;
			conv2_voltage_code <= setpoint_pkg::RST_CONV2_SETPOINT;
			conv2_low_voltage_code <= setpoint_pkg::RST_LOW_SETPOINT;
		end else begin
			// Load whatever the write decode chose.
			limit_slew <= next_limit_slew;
			conv0_voltage_code <= next_conv0_voltage_code;
			conv0_low_voltage_code <= next_conv0_low_voltage_code;
			conv1_voltage_code <= next_conv1_voltage_code;
			conv1_low_voltage_code <= next_conv1_low_voltage_code;
			conv2_voltage_code <= next_conv2_voltage_code;
			conv2_low_voltage_code <= next_conv2_low_voltage_code;
		end
	end

	// Enable pins come from outside the clock domain, so they pass two flops.
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			// Pins read low after reset, so roof/floor mode starts on the floor code.
			pin_meta <= 3'h0;
			pin_sync <= 3'h0;
		end else begin
			// The first stage may go metastable; only the second stage feeds logic.
			pin_meta <= enable_pin;
			pin_sync <= pin_meta;
		end
	end

	// Roof/floor choice: with the mode on, a high pin picks the normal code.
	always_comb begin
		// Converter zero.
		active_code[0] = (roof_floor_sel[0] && !pin_sync[0]) ?
			conv0_low_voltage_code : conv0_voltage_code;
		// Converter one.
		active_code[1] = (roof_floor_sel[1] && !pin_sync[1]) ?
			conv1_low_voltage_code : conv1_voltage_code;
		// Converter two.
		active_code[2] = (roof_floor_sel[2] && !pin_sync[2]) ?
			conv2_low_voltage_code : conv2_voltage_code;
	end

	// One decoder per converter; floor and normal share the same mapping.
	// Three copies rather than one shared decoder, so all targets move together.
	for (genvar i = 0; i < 3; i++) begin : g_dec
		voltage_decoder u_dec (
			.code(active_code[i]),
			.millivolts(decoded_mv[i])
		);
	end

	// Limit and slew decode plus the read mux.
	always_comb begin
		// Split the stored byte into its two fields.
		limit_field = limit_slew[setpoint_pkg::LIMIT_LSB +: 3];
		slew_field = limit_slew[setpoint_pkg::SLEW_LSB +: 3];
		// Codes below the first documented one saturate at the lowest limit.
		if (limit_field < setpoint_pkg::LIMIT_FIRST_CODE) begin
			next_limit_ma = setpoint_pkg::LIMIT_BASE_MA;
		end else begin
			// Codes two to seven step linearly from the base.
			next_limit_ma = setpoint_pkg::LIMIT_BASE_MA + setpoint_pkg::LIMIT_STEP_MA
				* {10'h000, limit_field - setpoint_pkg::LIMIT_FIRST_CODE};
		end
		// The single rate serves both ramp directions.
		next_ramp_rate = setpoint_pkg::SLEW_TABLE[slew_field];
		// The default assumes a hit; only the final else drops it.
		next_rd_hit = 1'b1;
		// Read data is the raw stored byte; decoding serves only the outputs.
		next_rd_data = 8'h00;
		if (rd_addr == setpoint_pkg::ADDR_CONV3_LIMIT_SLEW) begin
			// Limit and slew, reserved bits included.
			next_rd_data = limit_slew;
		end else if (rd_addr == setpoint_pkg::ADDR_CONV0_SETPOINT) begin
			// Converter zero normal code.
			next_rd_data = conv0_voltage_code;
		end else if (rd_addr == setpoint_pkg::ADDR_CONV0_LOW) begin
			// Converter zero floor code.
			next_rd_data = conv0_low_voltage_code;
		end else if (rd_addr == setpoint_pkg::ADDR_CONV1_SETPOINT) begin
			// Converter one normal code.
			next_rd_data = conv1_voltage_code;
		end else if (rd_addr == setpoint_pkg::ADDR_CONV1_LOW) begin
			// Converter one floor code.
			next_rd_data = conv1_low_voltage_code;
		end else if (rd_addr == setpoint_pkg::ADDR_CONV2_SETPOINT) begin
			// Converter two normal code.
			next_rd_data = conv2_voltage_code;
		end else if (rd_addr == setpoint_pkg::ADDR_CONV2_LOW) begin
			// Converter two floor code.
			next_rd_data = conv2_low_voltage_code;
		end else begin
			// Unmapped here: reads zero and drops the hit flag.
			next_rd_hit = 1'b0;
		end
	end

	// Output flops so every output comes straight from a register.
	// Trade-off: one extra edge of latency buys outputs free of decode glitches.
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			// Outputs read zero while reset is held.
			rd_data <= 8'h00;
			rd_hit <= 1'b0;
			conv3_current_limit <= 3'h0;
			conv3_limit_ma <= 13'h0000;
			conv3_ramp_speed <= 3'h0;
			conv3_ramp_rate <= 12'h000;
			conv0_target_mv <= 12'h000;
			conv1_target_mv <= 12'h000;
			conv2_target_mv <= 12'h000;
		end else begin
			// Register the read mux and the decoded values.
			rd_data <= next_rd_data;
			rd_hit <= next_rd_hit;
			conv3_current_limit <= limit_field;
			conv3_limit_ma <= next_limit_ma;
			conv3_ramp_speed <= slew_field;
			conv3_ramp_rate <= next_ramp_rate;
			conv0_target_mv <= decoded_mv[0];
			conv1_target_mv <= decoded_mv[1];
			conv2_target_mv <= decoded_mv[2];
		end
	end
endmodule

// *** verilog/setpoint_pkg.sv ***
// Package of offsets, field layouts, reset values and decode constants for the set-point bank.
// Function
// - Limit codes 2..7 give 2.5..5.0 A, 0.5 steps
// - Limit code applies immediately, even while running
// - Slew codes 0..7 map 30 down to 0.4 mV/us
// - One slew setting serves rising and falling ramps
// - Codes 0x00..0x17: 500 mV plus 10 mV steps
// - Codes 0x18..0x9D: 735 mV plus 5 mV steps
// - Codes 0x9E..0xFF: 1420 mV plus 20 mV steps
// - Converters zero..two each hold a floor set point
// - Floor set points of one and two reset 0x00
// - Converter zero set point resets to 0x39
// - Converter one set point resets to 0x75
// - Converter two set point resets to 0xB1
// - Roof/floor mode: pin high normal, low floor
package setpoint_pkg;
	// Register addresses on the serial control port.
	localparam logic [7:0] ADDR_CONV3_LIMIT_SLEW = 8'h09;
	localparam logic [7:0] ADDR_CONV0_SETPOINT = 8'h0A;
	localparam logic [7:0] ADDR_CONV0_LOW = 8'h0B;
	localparam logic [7:0] ADDR_CONV1_SETPOINT = 8'h0C;
	localparam logic [7:0] ADDR_CONV1_LOW = 8'h0D;
	localparam logic [7:0] ADDR_CONV2_SETPOINT = 8'h0E;
	localparam logic [7:0] ADDR_CONV2_LOW = 8'h0F;
	// Field positions of the limit and slew register.
	localparam int LIMIT_LSB = 3;
	localparam int SLEW_LSB = 0;
	// Reset values.
	localparam logic [7:0] RST_CONV3_LIMIT_SLEW = 8'h2A;
	localparam logic [7:0] RST_CONV0_SETPOINT = 8'h39;
	localparam logic [7:0] RST_CONV1_SETPOINT = 8'h75;
	localparam logic [7:0] RST_CONV2_SETPOINT = 8'hB1;
	localparam logic [7:0] RST_LOW_SETPOINT = 8'h00;
	// Set-point decode segments, in millivolts.
	localparam logic [7:0] SEG1_FIRST = 8'h18;
	localparam logic [7:0] SEG2_FIRST = 8'h9E;
	localparam logic [11:0] SEG0_BASE_MV = 12'h1F4;
	localparam logic [11:0] SEG1_BASE_MV = 12'h2DF;
	localparam logic [11:0] SEG2_BASE_MV = 12'h58C;
	localparam logic [11:0] SEG0_STEP_MV = 12'h00A;
	localparam logic [11:0] SEG1_STEP_MV = 12'h005;
	localparam logic [11:0] SEG2_STEP_MV = 12'h014;
	// Current limit decode, in milliamps: base at code 2, 500 mA per step.
	localparam logic [2:0] LIMIT_FIRST_CODE = 3'h2;
	localparam logic [12:0] LIMIT_BASE_MA = 13'h09C4;
	localparam logic [12:0] LIMIT_STEP_MA = 13'h01F4;
	// Slew rates in units of 0.01 mV/us, indexed by code.
	localparam logic [11:0] SLEW_TABLE [8] = '{12'hBB8, 12'h5DC, 12'h3E8, 12'h2EE,
		12'h17C, 12'h0BE, 12'h05E, 12'h028};
endpackage

// *** verilog/voltage_decoder.sv ***
// Piecewise decoder from an 8-bit set-point code to output millivolts.
`timescale 1ns/1ps
module voltage_decoder (
	input wire logic [7:0] code,
	output logic [11:0] millivolts
);
	// Three linear segments; the upper two subtract their first code from the input.
	always_comb begin
		if (code < setpoint_pkg::SEG1_FIRST) begin
			// Lowest segment, 10 mV per step.
			millivolts = setpoint_pkg::SEG0_BASE_MV + setpoint_pkg::SEG0_STEP_MV * {4'h0, code};
		end else if (code < setpoint_pkg::SEG2_FIRST) begin
			// Middle segment, 5 mV per step.
			millivolts = setpoint_pkg::SEG1_BASE_MV
				+ setpoint_pkg::SEG1_STEP_MV * {4'h0, code - setpoint_pkg::SEG1_FIRST};
		end else begin
			// Top segment, 20 mV per step.
			millivolts = setpoint_pkg::SEG2_BASE_MV
				+ setpoint_pkg::SEG2_STEP_MV * {4'h0, code - setpoint_pkg::SEG2_FIRST};
		end
	end
endmodule
